// *** asm_uart.sv ***
// Contract
// - Receive invert set makes low the idle receive level, else high; with infrared coding on, set gives idle high and clear idle low.
// - Baud generator gives 4 ticks per bit in high speed, else 16.
// - Format 11 is 9 bits; 10 odd, 01 even, 00 none, all 8 bits.
// - Stop count set sends two stop bits, clear sends one.
// - Infrared coding works only with the 16-tick bit clock.
// - Transmit event on load (00), all done (01), or buffer emptied (10).
// - Transmit invert sets idle low plainly, idle high with infrared coding.
// - Break sends start, twelve zeros, stop; hardware then clears the request.
// - Transmit disable aborts, flushes buffer, releases the pin.
// - Buffer-full flag is high when no further character fits.
// - Shift-empty flag is one only when shifter and buffer are empty.
// - Receive event at four (11), three (10) or any (0x) characters stored.
// - Address detect in 9-bit mode keeps only characters with ninth bit set.
// - Receiver idle flag is one while no character is being received.
// - Parity error flag belongs to the character at the buffer head.
// - Framing error flag belongs to the character at the buffer head.
// - Overflow sets overrun; software clears it, emptying buffer and shifter.
// - Data available is high while the receive buffer holds a character.
// - Transmit and receive each have a four-entry character buffer.
// - Module disable idles everything and returns pins to the port.
// - Loopback routes transmitted data into the own receiver.
//
// Design decisions made here: the register offsets and the AXI4-Lite interface to the registers.
`timescale 1ns/100ps
`include "asm_uart_consts.svh"

module asm_uart (
  // Clock and reset
  input  wire logic        CLK,
  input  wire logic        RESETN,
  // AXI4-Lite write address and data
  input  wire logic [7:0]  AWADDR,
  input  wire logic        AWVALID,
  output logic             AWREADY,
  input  wire logic [31:0] WDATA,
  input  wire logic [3:0]  WSTRB,
  input  wire logic        WVALID,
  output logic             WREADY,
  // AXI4-Lite write response
  output logic [1:0]       BRESP,
  output logic             BVALID,
  input  wire logic        BREADY,
  // AXI4-Lite read
  input  wire logic [7:0]  ARADDR,
  input  wire logic        ARVALID,
  output logic             ARREADY,
  output logic [31:0]      RDATA,
  output logic [1:0]       RRESP,
  output logic             RVALID,
  input  wire logic        RREADY,
  // Serial line
  input  wire logic        SERIAL_RX_PIN,
  output logic             SERIAL_TX_PIN,
  output logic             SERIAL_TX_OE,
  // Event pulses
  output logic             TX_EVENT,
  output logic             RX_EVENT
);

  asm_uart_pkg::asm_state_t q;
  asm_uart_pkg::asm_state_t d;

  // Byte-lane merge of a 16-bit register
  function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] data,
                                          input logic [3:0] strb);
    merge16 = old;
    if (strb[0]) merge16[7:0] = data[7:0];
    if (strb[1]) merge16[15:8] = data[15:8];
  endfunction : merge16

  // Data bits of a frame for a format code
  function automatic logic [3:0] data_bits(input logic [1:0] fmt);
    data_bits = (fmt == `ASM_FMT_9N) ? `ASM_BITS_NINE : `ASM_BITS_EIGHT;
  endfunction : data_bits

  // Parity present for a format code
  function automatic logic has_parity(input logic [1:0] fmt);
    has_parity = (fmt == `ASM_FMT_8O) || (fmt == `ASM_FMT_8E);
  endfunction : has_parity

  // Read-back of a register; unmapped reads as zero
  function automatic logic [31:0] reg_read(input logic [7:0] addr, input asm_uart_pkg::asm_state_t s);
    logic [15:0] sta;
    logic [10:0] head;
    sta = s.sta_ctl;
    head = s.rx_mem[s.rx_rd];
    sta[`ASM_STA_TXBF] = (s.tx_cnt == `ASM_FIFO_DEPTH);
    sta[`ASM_STA_TX_SHIFT_EMPTY] = (s.tx_st == asm_uart_pkg::ASM_IDLE) && (s.tx_cnt == 3'h0);
    sta[`ASM_STA_RECEIVER_IDLE] = (s.rx_st == asm_uart_pkg::ASM_IDLE);
    sta[`ASM_STA_PARITY_ERROR] = (s.rx_cnt != 3'h0) && head[10];
    sta[`ASM_STA_FRAMING_ERROR] = (s.rx_cnt != 3'h0) && head[9];
    sta[`ASM_STA_OVERRUN_ERROR] = s.overrun_error;
    sta[`ASM_STA_RXDA] = (s.rx_cnt != 3'h0);
    case (addr)
      `ASM_OFS_MODE:   reg_read = {16'h0000, s.mode};
      `ASM_OFS_STAT:   reg_read = {16'h0000, sta};
      `ASM_OFS_RXDATA: reg_read = {23'h000000, (s.rx_cnt != 3'h0) ? head[8:0] : 9'h000};
      `ASM_OFS_BRG:    reg_read = {16'h0000, s.brg_div};
      default:         reg_read = 32'h00000000;
    endcase
  endfunction : reg_read

  function automatic logic mapped(input logic [7:0] addr);
    mapped = (addr == `ASM_OFS_MODE) || (addr == `ASM_OFS_STAT) || (addr == `ASM_OFS_TXDATA)
          || (addr == `ASM_OFS_RXDATA) || (addr == `ASM_OFS_BRG);
  endfunction : mapped

  // Bus handshakes; one write and one read in flight at most
  assign AWREADY = !q.aw_held && !q.bvalid;
  assign WREADY  = !q.w_held && !q.bvalid;
  assign ARREADY = !q.rvalid;

  // Outputs straight from state flops
  assign BVALID        = q.bvalid;
  assign BRESP         = q.bresp;
  assign RVALID        = q.rvalid;
  assign RDATA         = q.rdata;
  assign RRESP         = q.rresp;
  assign SERIAL_TX_PIN = q.tx_pin;
  assign SERIAL_TX_OE  = q.tx_oe;
  assign TX_EVENT      = q.tx_evt;
  assign RX_EVENT      = q.rx_evt;

  // Next-state logic for the whole block
  always_comb begin
    logic [15:0] sta_new;
    logic [3:0]  tpb_last;
    logic [3:0]  tpb_half;
    logic [1:0]  fmt;
    logic        hs;
    logic        ir_on;
    logic        en;
    logic        tx_push;
    logic        tx_pop;
    logic        rx_push;
    logic        rx_pop;
    logic        overrun_error_set;
    logic        overrun_error_clr;
    logic        rx_raw;
    logic        rx_bit;
    logic        tx_bit_end;
    logic        rx_sample;
    logic [8:0]  rx_char;
    logic [8:0]  tx_char;
    logic [10:0] rx_entry;
    logic        ir_pulse;
    sta_new  = 16'h0000;
    tx_push  = 1'b0;
    tx_pop   = 1'b0;
    rx_push  = 1'b0;
    rx_pop   = 1'b0;
    overrun_error_set = 1'b0;
    overrun_error_clr = 1'b0;
    rx_char  = 9'h000;
    rx_entry = 11'h000;
    tx_char  = q.tx_mem[q.tx_rd];
    d        = q;
    d.tx_evt = 1'b0;
    d.rx_evt = 1'b0;
    fmt      = q.mode[`ASM_MODE_FMT_HI:`ASM_MODE_FMT_LO];
    hs       = q.mode[`ASM_MODE_HSPD];
    en       = q.mode[`ASM_MODE_EN];
    // infrared coding only at 16 ticks per bit
    ir_on    = q.mode[`ASM_MODE_INFRARED_CODEC_ENABLE] && !hs;
    // 4 or 16 ticks per bit
    tpb_last = hs ? `ASM_TPB_LAST_HS : `ASM_TPB_LAST_STD;
    tpb_half = hs ? `ASM_TPB_HALF_HS : `ASM_TPB_HALF_STD;

    // Baud tick every brg_div+1 clocks
    d.tick = 1'b0;
    if (q.brg_cnt >= q.brg_div) begin
      d.brg_cnt = 16'h0000;
      d.tick = 1'b1;
    end else begin
      d.brg_cnt = q.brg_cnt + 16'h0001;
    end

    // Write channel capture, either order
    if (AWVALID && AWREADY) begin
      d.aw_held = 1'b1;
      d.aw_addr = AWADDR;
    end
    if (WVALID && WREADY) begin
      d.w_held = 1'b1;
      d.w_data = WDATA;
      d.w_strb = WSTRB;
    end
    if (q.bvalid && BREADY) d.bvalid = 1'b0;

    // Register write once address and data are both held
    if (q.aw_held && q.w_held) begin
      d.aw_held = 1'b0;
      d.w_held = 1'b0;
      d.bvalid = 1'b1;
      d.bresp = mapped(q.aw_addr) ? `ASM_RESP_OKAY : `ASM_RESP_SLVERR;
      case (q.aw_addr)
        `ASM_OFS_MODE: d.mode = merge16(q.mode, q.w_data, q.w_strb) & `ASM_MODE_WMASK;
        `ASM_OFS_STAT: begin
          sta_new = merge16({q.sta_ctl[15:2], q.overrun_error, 1'b0}, q.w_data, q.w_strb);
          d.sta_ctl = sta_new & `ASM_STA_WMASK;
          overrun_error_clr = q.overrun_error && !sta_new[`ASM_STA_OVERRUN_ERROR];
        end
        `ASM_OFS_TXDATA: tx_push = q.w_strb[0] && (q.tx_cnt != `ASM_FIFO_DEPTH);
        `ASM_OFS_BRG: d.brg_div = merge16(q.brg_div, q.w_data, q.w_strb);
        default: d.bresp = `ASM_RESP_SLVERR;
      endcase
    end

    // Read channel; a data read pops the receive buffer
    if (q.rvalid && RREADY) d.rvalid = 1'b0;
    if (ARVALID && ARREADY) begin
      d.rvalid = 1'b1;
      d.rdata = reg_read(ARADDR, q);
      d.rresp = mapped(ARADDR) ? `ASM_RESP_OKAY : `ASM_RESP_SLVERR;
      rx_pop = (ARADDR == `ASM_OFS_RXDATA) && (q.rx_cnt != 3'h0);
    end

    // Transmit bit engine
    tx_bit_end = q.tick && (q.tx_sub == tpb_last);
    if (q.tx_st != asm_uart_pkg::ASM_IDLE && q.tick) begin
      d.tx_sub = (q.tx_sub == tpb_last) ? 4'h0 : q.tx_sub + 4'h1;
    end
    case (q.tx_st)
      asm_uart_pkg::ASM_IDLE: begin
        d.tx_line = 1'b1;
        d.tx_sub = 4'h0;
        if (q.sta_ctl[`ASM_STA_BRK]) begin
          d.tx_brk = 1'b1;
          d.tx_shift = 12'h000;
          d.tx_st = asm_uart_pkg::ASM_START;
          d.tx_line = 1'b0;
        end else if (q.tx_cnt != 3'h0) begin
          tx_pop = 1'b1;
          d.tx_shift = {3'h0, tx_char};
          d.tx_par = ^tx_char[7:0];
          d.tx_st = asm_uart_pkg::ASM_START;
          d.tx_line = 1'b0;
          if ({q.sta_ctl[`ASM_STA_TXISEL1], q.sta_ctl[`ASM_STA_TXISEL0]} == `ASM_TXI_LOAD) begin
            d.tx_evt = 1'b1;
          end
          if ({q.sta_ctl[`ASM_STA_TXISEL1], q.sta_ctl[`ASM_STA_TXISEL0]} == `ASM_TXI_EMPTY) begin
            d.tx_evt = (q.tx_cnt == 3'h1) && !tx_push;
          end
        end
      end
      asm_uart_pkg::ASM_START: begin
        if (tx_bit_end) begin
          d.tx_st = asm_uart_pkg::ASM_DATA;
          d.tx_bits = 4'h0;
          d.tx_line = q.tx_shift[0];
        end
      end
      asm_uart_pkg::ASM_DATA: begin
        if (tx_bit_end) begin
          d.tx_shift = q.tx_shift >> 1;
          d.tx_bits = q.tx_bits + 4'h1;
          d.tx_line = q.tx_shift[1];
          if (q.tx_bits == (q.tx_brk ? `ASM_BITS_BREAK : data_bits(fmt)) - 4'h1) begin
            if (has_parity(fmt) && !q.tx_brk) begin
              d.tx_st = asm_uart_pkg::ASM_PARITY;
              d.tx_line = q.tx_par ^ (fmt == `ASM_FMT_8O);
            end else begin
              d.tx_st = asm_uart_pkg::ASM_STOP;
              d.tx_line = 1'b1;
              d.tx_stop_left = q.mode[`ASM_MODE_STOP2];
            end
          end
        end
      end
      asm_uart_pkg::ASM_PARITY: begin
        if (tx_bit_end) begin
          d.tx_st = asm_uart_pkg::ASM_STOP;
          d.tx_line = 1'b1;
          d.tx_stop_left = q.mode[`ASM_MODE_STOP2];
        end
      end
      asm_uart_pkg::ASM_STOP: begin
        if (tx_bit_end && q.tx_stop_left) begin
          d.tx_stop_left = 1'b0;
        end else if (tx_bit_end) begin
          d.tx_st = asm_uart_pkg::ASM_IDLE;
          if (q.tx_brk) begin
            d.tx_brk = 1'b0;
            d.sta_ctl[`ASM_STA_BRK] = 1'b0;
          end else if ({q.sta_ctl[`ASM_STA_TXISEL1], q.sta_ctl[`ASM_STA_TXISEL0]} == `ASM_TXI_DONE) begin
            d.tx_evt = (q.tx_cnt == 3'h0) && !tx_push;
          end
        end
      end
      default: d.tx_st = asm_uart_pkg::ASM_IDLE;
    endcase

    if (tx_push) d.tx_mem[q.tx_rd + q.tx_cnt[1:0]] = q.w_data[8:0];
    if (tx_pop) d.tx_rd = q.tx_rd + 2'h1;
    d.tx_cnt = q.tx_cnt + {2'h0, tx_push} - {2'h0, tx_pop};

    // disable aborts, flushes and releases the pin
    if (!q.sta_ctl[`ASM_STA_TXEN] || !en) begin
      d.tx_st = asm_uart_pkg::ASM_IDLE;
      d.tx_cnt = 3'h0;
      d.tx_rd = 2'h0;
      d.tx_line = 1'b1;
      d.tx_brk = 1'b0;
      d.tx_evt = 1'b0;
    end

    // pin level; infrared sends a short pulse per zero bit
    ir_pulse = !q.tx_line && (q.tx_sub < `ASM_IR_PULSE);
    d.tx_pin = (ir_on ? ir_pulse : q.tx_line) ^ q.sta_ctl[`ASM_STA_TXINV];
    // pins back to the port while disabled
    d.tx_oe = en && q.sta_ctl[`ASM_STA_TXEN];

    // Receive pin synchroniser; change taken when stages two and three agree
    d.rx_sync = {q.rx_sync[1:0], SERIAL_RX_PIN};
    if (q.rx_sync[1] == q.rx_sync[2]) d.rx_stable = q.rx_sync[2];
    // polarity of the idle receive level
    rx_raw = q.rx_stable ^ q.mode[`ASM_MODE_RXINV];
    // Infrared pulse stretched over one bit time
    if (rx_raw) begin
      d.ir_hold = `ASM_TPB_LAST_STD;
    end else if (q.tick && q.ir_hold != 4'h0) begin
      d.ir_hold = q.ir_hold - 4'h1;
    end
    rx_bit = ir_on ? !(rx_raw || q.ir_hold != 4'h0) : rx_raw;
    // loopback takes the own transmit bit
    if (q.mode[`ASM_MODE_LOOPBACK_SELECT]) rx_bit = q.tx_line;

    // Receive bit engine; samples at mid-bit
    rx_sample = q.tick && (q.rx_sub == tpb_last);
    if (q.tick && q.rx_st != asm_uart_pkg::ASM_IDLE) d.rx_sub = q.rx_sub + 4'h1;
    if (rx_sample) d.rx_sub = 4'h0;
    case (q.rx_st)
      asm_uart_pkg::ASM_IDLE: begin
        d.rx_sub = 4'h0;
        if (q.tick && !rx_bit) d.rx_st = asm_uart_pkg::ASM_START;
      end
      asm_uart_pkg::ASM_START: begin
        if (q.tick && q.rx_sub == tpb_half) begin
          d.rx_sub = 4'h0;
          d.rx_bits = 4'h0;
          d.rx_par = 1'b0;
          d.rx_st = rx_bit ? asm_uart_pkg::ASM_IDLE : asm_uart_pkg::ASM_DATA;
        end
      end
      asm_uart_pkg::ASM_DATA: begin
        if (rx_sample) begin
          d.rx_shift = {rx_bit, q.rx_shift[8:1]};
          d.rx_par = q.rx_par ^ rx_bit;
          d.rx_bits = q.rx_bits + 4'h1;
          d.rx_parity_error = 1'b0;
          if (q.rx_bits == data_bits(fmt) - 4'h1) begin
            d.rx_st = has_parity(fmt) ? asm_uart_pkg::ASM_PARITY : asm_uart_pkg::ASM_STOP;
          end
        end
      end
      asm_uart_pkg::ASM_PARITY: begin
        if (rx_sample) begin
          d.rx_parity_error = (q.rx_par ^ rx_bit) != (fmt == `ASM_FMT_8O);
          d.rx_st = asm_uart_pkg::ASM_STOP;
        end
      end
      asm_uart_pkg::ASM_STOP: begin
        if (rx_sample) begin
          d.rx_st = asm_uart_pkg::ASM_IDLE;
          rx_char = (fmt == `ASM_FMT_9N) ? q.rx_shift : {1'b0, q.rx_shift[8:1]};
          // framing error kept with the character
          rx_entry = {q.rx_parity_error, !rx_bit, rx_char};
          // address detect drops data characters in 9-bit mode
          if (!(q.sta_ctl[`ASM_STA_ADDRESS_DETECT_ENABLE] && fmt == `ASM_FMT_9N && !rx_char[8])) begin
            if (q.overrun_error) begin
              rx_push = 1'b0;
            end else if (q.rx_cnt == `ASM_FIFO_DEPTH && !rx_pop) begin
              overrun_error_set = 1'b1;
            end else begin
              rx_push = 1'b1;
            end
          end
        end
      end
      default: d.rx_st = asm_uart_pkg::ASM_IDLE;
    endcase

    if (rx_push) d.rx_mem[q.rx_rd + q.rx_cnt[1:0]] = rx_entry;
    if (rx_pop) d.rx_rd = q.rx_rd + 2'h1;
    d.rx_cnt = q.rx_cnt + {2'h0, rx_push} - {2'h0, rx_pop};
    // receive event by fill level after the transfer
    if (rx_push) begin
      case (q.sta_ctl[`ASM_STA_RXISEL_HI:`ASM_STA_RXISEL_LO])
        `ASM_RXI_FULL: d.rx_evt = (d.rx_cnt == `ASM_FIFO_DEPTH);
        `ASM_RXI_3Q:   d.rx_evt = (d.rx_cnt == `ASM_FIFO_3Q);
        default:       d.rx_evt = 1'b1;
      endcase
    end

    // set wins over clear; clear empties buffer and shifter
    if (overrun_error_set) begin
      d.overrun_error = 1'b1;
    end else if (overrun_error_clr) begin
      d.overrun_error = 1'b0;
      d.rx_cnt = 3'h0;
      d.rx_rd = 2'h0;
      d.rx_st = asm_uart_pkg::ASM_IDLE;
      d.rx_evt = 1'b0;
    end

    if (!en) begin
      d.rx_st = asm_uart_pkg::ASM_IDLE;
      d.rx_cnt = 3'h0;
      d.rx_rd = 2'h0;
      d.rx_evt = 1'b0;
      d.brg_cnt = 16'h0000;
      d.tick = 1'b0;
    end

    // Synchronous reset; line levels start idle high
    if (!RESETN) begin
      d = '0;
      d.tx_line = 1'b1;
      d.tx_pin = 1'b1;
      d.rx_sync = 3'h7;
      d.rx_stable = 1'b1;
    end
  end

  // State register
  always_ff @(posedge CLK) begin
    q <= d;
  end

endmodule : asm_uart

// *** asm_uart_consts.svh ***
`ifndef ASM_UART_CONSTS_SVH
`define ASM_UART_CONSTS_SVH

// Register byte offsets
`define ASM_OFS_MODE      8'h00
`define ASM_OFS_STAT      8'h04
`define ASM_OFS_TXDATA    8'h08
`define ASM_OFS_RXDATA    8'h0C
`define ASM_OFS_BRG       8'h10

// Mode register fields
`define ASM_MODE_EN       15
`define ASM_MODE_INFRARED_CODEC_ENABLE     12
`define ASM_MODE_LOOPBACK_SELECT   6
`define ASM_MODE_RXINV    4
`define ASM_MODE_HSPD     3
`define ASM_MODE_FMT_HI   2
`define ASM_MODE_FMT_LO   1
`define ASM_MODE_STOP2    0
`define ASM_MODE_WMASK    16'h905F

// Status and control register fields
`define ASM_STA_TXISEL1   15
`define ASM_STA_TXINV     14
`define ASM_STA_TXISEL0   13
`define ASM_STA_BRK       11
`define ASM_STA_TXEN      10
`define ASM_STA_TXBF      9
`define ASM_STA_TX_SHIFT_EMPTY      8
`define ASM_STA_RXISEL_HI 7
`define ASM_STA_RXISEL_LO 6
`define ASM_STA_ADDRESS_DETECT_ENABLE     5
`define ASM_STA_RECEIVER_IDLE     4
`define ASM_STA_PARITY_ERROR      3
`define ASM_STA_FRAMING_ERROR      2
`define ASM_STA_OVERRUN_ERROR      1
`define ASM_STA_RXDA      0
`define ASM_STA_WMASK     16'hECE0

// Frame format and interrupt select codes
`define ASM_FMT_9N        2'h3
`define ASM_FMT_8O        2'h2
`define ASM_FMT_8E        2'h1
`define ASM_TXI_LOAD      2'h0
`define ASM_TXI_DONE      2'h1
`define ASM_TXI_EMPTY     2'h2
`define ASM_RXI_FULL      2'h3
`define ASM_RXI_3Q        2'h2

// Bit timing in baud ticks; frame lengths in bits
`define ASM_TPB_LAST_HS   4'h3
`define ASM_TPB_LAST_STD  4'hF
`define ASM_TPB_HALF_HS   4'h1
`define ASM_TPB_HALF_STD  4'h7
`define ASM_IR_PULSE      4'h3
`define ASM_BITS_BREAK    4'hC
`define ASM_BITS_NINE     4'h9
`define ASM_BITS_EIGHT    4'h8

// Buffers
`define ASM_FIFO_DEPTH    3'h4
`define ASM_FIFO_3Q       3'h3

// Bus answers
`define ASM_RESP_OKAY     2'h0
`define ASM_RESP_SLVERR   2'h2

`endif

// *** asm_uart_pkg.sv ***
package asm_uart_pkg;

  // Shared bit-engine states, Gray along idle-start-data-parity-stop
  typedef enum logic [2:0] {
    ASM_IDLE   = 3'h0,
    ASM_START  = 3'h1,
    ASM_DATA   = 3'h3,
    ASM_PARITY = 3'h2,
    ASM_STOP   = 3'h6
  } asm_bit_st_t;

  // Whole block state
  typedef struct packed {
    logic [15:0]      mode;
    logic [15:0]      sta_ctl;
    logic [15:0]      brg_div;
    logic [15:0]      brg_cnt;
    logic             tick;
    logic [3:0][8:0]  tx_mem;
    logic [1:0]       tx_rd;
    logic [2:0]       tx_cnt;
    asm_bit_st_t      tx_st;
    logic [11:0]      tx_shift;
    logic [3:0]       tx_bits;
    logic [3:0]       tx_sub;
    logic             tx_par;
    logic             tx_brk;
    logic             tx_stop_left;
    logic             tx_line;
    logic             tx_pin;
    logic             tx_oe;
    logic             tx_evt;
    logic [2:0]       rx_sync;
    logic             rx_stable;
    logic [3:0]       ir_hold;
    logic [3:0][10:0] rx_mem;
    logic [1:0]       rx_rd;
    logic [2:0]       rx_cnt;
    asm_bit_st_t      rx_st;
    logic [8:0]       rx_shift;
    logic [3:0]       rx_bits;
    logic [3:0]       rx_sub;
    logic             rx_par;
    logic             rx_parity_error;
    logic             overrun_error;
    logic             rx_evt;
    logic             aw_held;
    logic [7:0]       aw_addr;
    logic             w_held;
    logic [31:0]      w_data;
    logic [3:0]       w_strb;
    logic             bvalid;
    logic [1:0]       bresp;
    logic             rvalid;
    logic [31:0]      rdata;
    logic [1:0]       rresp;
  } asm_state_t;

endpackage : asm_uart_pkg

// *** asm_uart_checker.sv ***
`timescale 1ns/100ps
module asm_uart_checker (
  // Clock and reset
  input wire logic        CLK,
  input wire logic        RESETN,
  // Bus handshakes
  input wire logic        AWREADY,
  input wire logic        WREADY,
  input wire logic [1:0]  BRESP,
  input wire logic        BVALID,
  input wire logic        BREADY,
  input wire logic        ARVALID,
  input wire logic        ARREADY,
  input wire logic [31:0] RDATA,
  input wire logic        RVALID,
  input wire logic        RREADY,
  // Line enable and events
  input wire logic        SERIAL_TX_OE,
  input wire logic        TX_EVENT,
  input wire logic        RX_EVENT
);
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RESETN);
  a_tx_evt_pulse: assert property (TX_EVENT |=> !TX_EVENT) else $error("tx event too wide");
  a_rx_evt_pulse: assert property (RX_EVENT |=> !RX_EVENT) else $error("rx event too wide");
  a_tx_evt_oe: assert property (TX_EVENT |-> SERIAL_TX_OE || $past(SERIAL_TX_OE))
    else $error("tx event, pin released");
  // drive begins only after a write
  a_oe_by_write: assert property ($rose(SERIAL_TX_OE) |-> BVALID || $past(BVALID))
    else $error("pin driven unasked");
  // Answers stand until taken
  a_bresp_hold: assert property (BVALID && !BREADY |=> BVALID && $stable(BRESP))
    else $error("write answer dropped");
  a_rdata_hold: assert property (RVALID && !RREADY |=> RVALID && $stable(RDATA))
    else $error("read answer dropped");
  // No new write while answer waits, read answer one cycle on
  a_write_refuse: assert property (BVALID |-> !AWREADY && !WREADY) else $error("write not refused");
  a_read_answer: assert property (ARVALID && ARREADY |=> RVALID) else $error("read answer late");
  c_tx_evt: cover property (TX_EVENT);
  c_rx_evt: cover property (RX_EVENT);
  c_wr_wait: cover property (BVALID && !BREADY);
endmodule : asm_uart_checker

// *** asm_uart_peer.sv ***
`timescale 1ns/100ps
module asm_uart_peer (
  // Clock and bit length in clocks
  input wire logic       clk,
  input wire logic [4:0] bit_clks,
  // Line pair facing the block
  input wire logic       tx_line,
  input wire logic       tx_oe,
  output logic           rx_line,
  // Character taken off the line
  output logic           got,
  output logic [7:0]     got_char
);
  int i;
  initial begin
    rx_line = 1'b1;
    got = 1'b0;
    got_char = 8'h00;
  end
  // mid-bit sampling, pulse only on a high stop
  always begin
    @(negedge tx_line iff tx_oe);
    repeat (bit_clks / 2) @(posedge clk);
    for (i = 0; i < 8; i++) begin
      repeat (bit_clks) @(posedge clk);
      got_char[i] = tx_line;
    end
    repeat (bit_clks) @(posedge clk);
    got <= tx_line;
    @(posedge clk);
    got <= 1'b0;
  end
  // low bit first, line left high
  task automatic send(input logic [11:0] frame);
    for (int k = 0; k < 12; k++) begin
      rx_line <= frame[k];
      repeat (bit_clks) @(posedge clk);
    end
  endtask : send
endmodule : asm_uart_peer

// *** asm_uart_tb.sv ***
`timescale 1ns/100ps
module asm_uart_tb;
  logic        clk, resetn, awvalid, wvalid, bready, arvalid, rready, rx_pin, got;
  logic        awready, wready, bvalid, arready, rvalid, tx_pin, tx_oe, tx_evt, rx_evt;
  logic [1:0]  bresp, rresp;
  logic [4:0]  bit_clks;
  logic [7:0]  awaddr, araddr, got_char, c;
  logic [8:0]  d9;
  logic [31:0] wdata, rdata;
  logic [33:0] rd_q[$];
  logic [7:0]  ch_q[$];
  int          mismatches, total_checks, cycles, seed, n;
  // Receive cases: mode, payload with parity and stop, expected status
  logic [15:0] mode_t[6] = '{16'h8000, 16'h8002, 16'h8002, 16'h8004, 16'h8006, 16'h8008};
  logic [9:0]  pay_t[6] = '{10'h35A, 10'h301, 10'h201, 10'h303, 10'h3A5, 10'h3C3};
  logic [15:0] sta_t[6] = '{16'h0511, 16'h0511, 16'h0519, 16'h0511, 16'h0511, 16'h0511};
  asm_uart u_asm_uart (.CLK(clk), .RESETN(resetn), .AWADDR(awaddr), .AWVALID(awvalid),
    .AWREADY(awready), .WDATA(wdata), .WSTRB(4'h3), .WVALID(wvalid), .WREADY(wready),
    .BRESP(bresp), .BVALID(bvalid), .BREADY(bready), .ARADDR(araddr), .ARVALID(arvalid),
    .ARREADY(arready), .RDATA(rdata), .RRESP(rresp), .RVALID(rvalid), .RREADY(rready),
    .SERIAL_RX_PIN(rx_pin), .SERIAL_TX_PIN(tx_pin), .SERIAL_TX_OE(tx_oe),
    .TX_EVENT(tx_evt), .RX_EVENT(rx_evt));
  asm_uart_peer u_asm_uart_peer (.clk(clk), .bit_clks(bit_clks), .tx_line(tx_pin),
    .tx_oe(tx_oe), .rx_line(rx_pin), .got(got), .got_char(got_char));
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  // Each channel held until the rising edge that takes it
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    logic aw_p, w_p;
    aw_p = 1'b1;
    w_p = 1'b1;
    awaddr <= a;
    wdata <= {16'h0000, d};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    do begin
      @(posedge clk);
      if (aw_p && awready) begin
        aw_p = 1'b0;
        awvalid <= 1'b0;
      end
      if (w_p && wready) begin
        w_p = 1'b0;
        wvalid <= 1'b0;
      end
    end while (aw_p || w_p);
    // Ready raised after the request, so back-to-back calls never clash
    bready <= 1'b1;
    do @(posedge clk); while (bvalid !== 1'b1);
    bready <= 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [33:0] e);
    rd_q.push_back(e);
    araddr <= a;
    arvalid <= 1'b1;
    do @(posedge clk); while (arready !== 1'b1);
    arvalid <= 1'b0;
    rready <= 1'b1;
    do @(posedge clk); while (rvalid !== 1'b1);
    rready <= 1'b0;
  endtask : rd
  task automatic chk_val(input string what, input logic [33:0] e, input logic [33:0] s);
    total_checks++;
    if (s !== e) begin
      mismatches++;
      $display("[FAIL] %s expected %h seen %h", what, e, s);
    end
  endtask : chk_val
  task automatic chk_ch(input logic [7:0] e, input logic [7:0] s);
    total_checks++;
    if (s !== e) begin
      mismatches++;
      $display("[FAIL] line char expected %h seen %h", e, s);
    end
  endtask : chk_ch
  task automatic results;
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : results
  // Results settle before the falling edge ahead of their handshake
  always @(negedge clk) begin
    if (rvalid === 1'b1 && rready) chk_val("read", rd_q.pop_front(), {rresp, rdata});
    if (got === 1'b1) chk_ch(ch_q.pop_front(), got_char);
  end
  // Hang guard, several times the expected run
  always @(posedge clk) begin
    cycles++;
    if (cycles == 12000) begin
      mismatches++;
      results();
    end
  end
  initial begin
    resetn = 1'b0;
    {awvalid, wvalid, bready, arvalid, rready} = 5'h00;
    {awaddr, araddr, wdata} = 48'h0;
    bit_clks = 5'h10;
    seed = 75;
    repeat (2) @(posedge clk);
    resetn <= 1'b1;
    @(posedge clk);
    rd(8'h04, 34'h0110);
    rd(8'h20, 34'h2_0000_0000);
    wr(8'h00, 16'h8000);
    wr(8'h04, 16'h0400);
    // Shifter plus four queued, the sixth write is dropped
    for (n = 0; n < 5; n++) begin
      c = 8'($random(seed));
      ch_q.push_back(c);
      wr(8'h08, {8'h00, c});
    end
    wr(8'h08, 16'h00FF);
    rd(8'h04, 34'h0610);
    repeat (900) @(posedge clk);
    rd(8'h04, 34'h0510);
    // Formats, parity and fast bit clock on receive
    for (n = 0; n < 6; n++) begin
      bit_clks <= mode_t[n][3] ? 5'h04 : 5'h10;
      wr(8'h00, mode_t[n]);
      u_asm_uart_peer.send({1'b1, pay_t[n], 1'b0});
      repeat (8) @(posedge clk);
      rd(8'h04, {18'h0, sta_t[n]});
      d9 = (mode_t[n][2:1] == 2'h3) ? pay_t[n][8:0] : {1'b0, pay_t[n][7:0]};
      rd(8'h0C, {25'h0, d9});
    end
    // Fifth character overruns a four-entry buffer
    for (n = 0; n < 5; n++)
      u_asm_uart_peer.send({3'h7, 8'hA0 + 8'(n), 1'b0});
    repeat (8) @(posedge clk);
    rd(8'h04, 34'h0513);
    rd(8'h0C, 34'h0A0);
    wr(8'h04, 16'h0400);
    rd(8'h04, 34'h0510);
    u_asm_uart_peer.send({3'h7, 8'h5C, 1'b0});
    repeat (8) @(posedge clk);
    rd(8'h0C, 34'h05C);
    repeat (20) @(posedge clk);
    chk_val("leftover notes", 34'h0, 34'(ch_q.size() + rd_q.size()));
    results();
  end
endmodule : asm_uart_tb
bind asm_uart asm_uart_checker u_asm_uart_checker (.CLK(CLK), .RESETN(RESETN),
  .AWREADY(AWREADY), .WREADY(WREADY), .BRESP(BRESP), .BVALID(BVALID), .BREADY(BREADY),
  .ARVALID(ARVALID), .ARREADY(ARREADY), .RDATA(RDATA), .RVALID(RVALID), .RREADY(RREADY),
  .SERIAL_TX_OE(SERIAL_TX_OE), .TX_EVENT(TX_EVENT), .RX_EVENT(RX_EVENT));
